// *** eqtm_pkg.sv ***
/*
 Constants for the event queue threshold monitor: register offsets,
 field positions, reset values and threshold codes.
 Assumes a 32-bit APB register bus with byte addresses.
*/
package eqtm_pkg;

   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int unsigned NUM_Q     = 4;
   localparam int unsigned THR_W     = 5;
   localparam int unsigned THR_PITCH = 8;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_THR_CFG  = 8'h00;
   localparam logic [7:0] OFF_ERR      = 8'h04;
   localparam logic [7:0] OFF_ERR_CLR  = 8'h08;
   localparam logic [7:0] OFF_ERR_EN   = 8'h0C;
   localparam logic [7:0] OFF_QSTAT0   = 8'h10;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int unsigned THR0_LSB   = 0;
   localparam int unsigned THR1_LSB   = 8;
   localparam int unsigned THR2_LSB   = 16;
   localparam int unsigned THR3_LSB   = 24;
   localparam int unsigned ST_CNT_LSB = 8;
   localparam int unsigned ST_HWM_LSB = 16;
   localparam int unsigned ST_OVR_BIT = 24;

   // ----------------------------------------------------------------
   // Reset values and codes
   // ----------------------------------------------------------------
   localparam logic [4:0] THR_RST     = 5'h10;
   localparam logic [4:0] THR_DISABLE = 5'h11;
   localparam logic [4:0] CNT_RST     = 5'h00;
   localparam logic [3:0] FLAGS_RST   = 4'h0;

endpackage

// *** eqtm_monitor.sv ***
/*
 Event queue threshold monitor with its APB register slave.
 Compares each queue's valid entry count with its threshold, keeps
 sticky over-limit flags, high-water marks and one interrupt.
 Assumes the counts come from queue manager logic on clk (no sync)
 and lie within 0..10h.
*/
// Local design decisions: the APB register port and the placing of the registers.
// How it works
// - Queue 0 threshold bits 4:0, flag on >=
// - Queue 1 threshold bits 12:8, flag on >=
// - Queue 2 threshold bits 20:16, flag on >=
// - Queue 3 threshold bits 28:24, flag on >=
// - Thresholds 0..10h valid, reset to 16
// - Code 11h disables checks; 12h-1Fh reserved
// - Clear register clears status flag; mark restarts from present count
// - Valid counts range from 0 to 10h
`timescale 1ns/1ps
module eqtm_monitor
   import eqtm_pkg::*;
#(
   parameter int unsigned ADDR_W = 8
) (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    sys_rst,
   // APB slave
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [ADDR_W-1:0]       paddr,
   input  wire logic [31:0]             pwdata,
   input  wire logic [3:0]              pstrb,
   output logic                         pready,
   output logic [31:0]                  prdata,
   output logic                         pslverr,
   // Queue manager counts, one 5-bit count per queue
   input  wire logic [NUM_Q-1:0][4:0]   valid_entry_count,
   // Error flags and interrupt
   output logic [NUM_Q-1:0]             queue_over_limit_error,
   output logic                         irq
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [THR_W-1:0] thr_q [NUM_Q];
   logic [4:0]       hwm_q [NUM_Q];
   logic [NUM_Q-1:0] err_q;
   logic [NUM_Q-1:0] ovr_q;
   logic [NUM_Q-1:0] en_q;
   logic [NUM_Q-1:0] hit;
   logic [NUM_Q-1:0] clr;
   logic             irq_q;
   logic             pready_q;
   logic [31:0]      prdata_q;
   logic             pslverr_q;
   logic             wr_ok;
   logic             rd_go;
   logic [31:0]      rd_d;
   logic             map_d;
   logic [31:0]      cfg_rd;

   // Byte-address match against one register offset
   function automatic logic at_off(input logic [ADDR_W-1:0] a,
                                   input logic [7:0] off);
      at_off = (a == ADDR_W'(off));
   endfunction

   // True when the address falls on a queue status word
   function automatic logic at_qstat(input logic [ADDR_W-1:0] a);
      at_qstat = (a >= ADDR_W'(OFF_QSTAT0)) &&
                 (a < ADDR_W'(OFF_QSTAT0 + 8'(4 * NUM_Q))) &&
                 (a[1:0] == 2'h0);
   endfunction

   // ----------------------------------------------------------------
   // APB handshake
   // ----------------------------------------------------------------
   // One wait state: ready rises in the second access cycle, which
   // gives the read mux a full cycle before data is presented.
   assign rd_go = psel && penable && !pready_q;
   assign wr_ok = psel && penable && pready_q && pwrite;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pready_q <= 1'b0;
      end else begin
         pready_q <= rd_go;
      end
   end

   // Read mux; unmapped addresses answer zero with an error
   always_comb begin
      rd_d  = 32'h0000_0000;
      map_d = 1'b1;
      if (at_off(paddr, OFF_THR_CFG)) begin
         rd_d = cfg_rd;
      end else if (at_off(paddr, OFF_ERR)) begin
         rd_d[NUM_Q-1:0] = err_q;
      end else if (at_off(paddr, OFF_ERR_CLR)) begin
         rd_d = 32'h0000_0000;           // Write-only, reads zero
      end else if (at_off(paddr, OFF_ERR_EN)) begin
         rd_d[NUM_Q-1:0] = en_q;
      end else if (at_qstat(paddr)) begin
         for (int i = 0; i < NUM_Q; i++) begin
            if (paddr[3:2] == 2'(i)) begin
               rd_d[ST_OVR_BIT]            = ovr_q[i];
               rd_d[ST_HWM_LSB +: 5]       = hwm_q[i];
               rd_d[ST_CNT_LSB +: 5]       = valid_entry_count[i];
            end
         end
      end else begin
         map_d = 1'b0;
      end
   end

   // Read data and error are held through the ready cycle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (rd_go) begin
         prdata_q  <= pwrite ? 32'h0000_0000 : rd_d;
         pslverr_q <= !map_d;
      end
   end

   assign pready  = pready_q;
   assign prdata  = prdata_q;
   assign pslverr = pslverr_q;

   // ----------------------------------------------------------------
   // Threshold configuration
   // ----------------------------------------------------------------
   // Each threshold sits in its own byte lane, so pstrb selects it.
   // Reserved codes are stored as written; they never match a legal
   // count, so a stray 12h-1Fh behaves like a disabled queue.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < NUM_Q; i++) begin
            thr_q[i] <= THR_RST;
         end
      end else if (wr_ok && at_off(paddr, OFF_THR_CFG)) begin
         for (int i = 0; i < NUM_Q; i++) begin
            if (pstrb[i]) begin
               thr_q[i] <= pwdata[THR_PITCH*i +: THR_W];
            end
         end
      end
   end

   // Readback; reserved bits read zero
   assign cfg_rd = {3'h0, thr_q[3],
                    3'h0, thr_q[2],
                    3'h0, thr_q[1],
                    3'h0, thr_q[0]};

   // ----------------------------------------------------------------
   // Interrupt enable register
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         en_q <= FLAGS_RST;
      end else if (wr_ok && at_off(paddr, OFF_ERR_EN) && pstrb[0]) begin
         en_q <= pwdata[NUM_Q-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Per-queue comparison
   // ----------------------------------------------------------------
   // Evaluated combinationally every cycle; flags land one edge later
   genvar g;
   generate
      for (g = 0; g < NUM_Q; g++) begin : g_cmp
         assign hit[g] = (thr_q[g] != THR_DISABLE) &&
                         (valid_entry_count[g] >= thr_q[g]);
         assign clr[g] = wr_ok && at_off(paddr, OFF_ERR_CLR) &&
                         pstrb[0] && pwdata[g];
      end
   endgenerate

   // ----------------------------------------------------------------
   // Sticky flags
   // ----------------------------------------------------------------
   // A new hit in the clearing cycle wins, so no event is lost.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         err_q <= FLAGS_RST;
      end else begin
         err_q <= hit | (err_q & ~clr);
      end
   end

   // Status copy of the flag, cleared by the same write
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ovr_q <= FLAGS_RST;
      end else begin
         ovr_q <= hit | (ovr_q & ~clr);
      end
   end

   // ----------------------------------------------------------------
   // High-water marks
   // ----------------------------------------------------------------
   // On clear the mark restarts from the present count rather than
   // zero, so entries already queued are not forgotten.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < NUM_Q; i++) begin
            hwm_q[i] <= CNT_RST;
         end
      end else begin
         for (int i = 0; i < NUM_Q; i++) begin
            if (clr[i]) begin
               hwm_q[i] <= valid_entry_count[i];
            end else if (valid_entry_count[i] > hwm_q[i]) begin
               hwm_q[i] <= valid_entry_count[i];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupt
   // ----------------------------------------------------------------
   // Registered, so it trails the flag by one cycle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(err_q & en_q);
      end
   end

   assign irq                    = irq_q;
   assign queue_over_limit_error = err_q;

endmodule // eqtm_monitor

// *** eqtm_monitor_sva.sv ***
/* Port checker for eqtm_monitor.
 Assumes one clock and a synchronous high reset. */
`timescale 1ns/1ps
module eqtm_monitor_sva
   import eqtm_pkg::*;
#(parameter int unsigned ADDR_W = 8) (
   // Clock and reset
   input wire logic                  clk,
   input wire logic                  sys_rst,
   // APB
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [ADDR_W-1:0]     paddr,
   input wire logic [31:0]           pwdata,
   input wire logic [3:0]            pstrb,
   input wire logic                  pready,
   input wire logic [31:0]           prdata,
   input wire logic                  pslverr,
   // Queues and flags
   input wire logic [NUM_Q-1:0][4:0] valid_entry_count,
   input wire logic [NUM_Q-1:0]      queue_over_limit_error,
   input wire logic                  irq
);
   // ----
   // Register mirror
   // ----
   logic [3:0][4:0] thr_q;
   logic [3:0]      en_q;
   wire logic wr  = psel & penable & pready & pwrite;
   wire logic clr = wr && paddr == OFF_ERR_CLR;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Mirror follows completed writes only, as the slave does
   always_ff @(posedge clk) begin
      for (int i = 0; i < 4; i++) begin
         if (sys_rst) thr_q[i] <= THR_RST;
         else if (wr && paddr == OFF_THR_CFG && pstrb[i])
            thr_q[i] <= pwdata[8*i +: 5];
      end
   end
   // Enable mirror
   always_ff @(posedge clk) begin
      if (sys_rst) en_q <= 4'h0;
      else if (wr && paddr == OFF_ERR_EN && pstrb[0]) en_q <= pwdata[3:0];
   end
   for (genvar g = 0; g < NUM_Q; g++) begin : gq
      chk_flag_set: assert property (
         valid_entry_count[g] >= thr_q[g] |=> queue_over_limit_error[g])
         else $error("flag not raised");
      chk_flag_cause: assert property (
         !queue_over_limit_error[g] && valid_entry_count[g] < thr_q[g]
         |=> !queue_over_limit_error[g]) else $error("flag without cause");
      chk_flag_sticky: assert property (
         queue_over_limit_error[g] && !(clr && pwdata[g])
         |=> queue_over_limit_error[g]) else $error("flag dropped");
      chk_flag_clear: assert property (
         clr && pstrb[0] && pwdata[g] && valid_entry_count[g] < thr_q[g]
         |=> !queue_over_limit_error[g]) else $error("flag not cleared");
   end
   chk_cfg_read: assert property (
      psel && penable && pready && !pwrite && paddr == OFF_THR_CFG
      |-> prdata == {3'h0, thr_q[3], 3'h0, thr_q[2], 3'h0, thr_q[1],
                     3'h0, thr_q[0]}) else $error("config readback");
   chk_irq_level: assert property (
      irq == $past(|(queue_over_limit_error & en_q))) else $error("irq level");
   chk_ready_wait: assert property (
      psel && !penable |=> !pready ##1 pready) else $error("wait state");
   chk_bad_addr: assert property (
      pready && paddr > 'h1C |-> pslverr) else $error("unmapped accepted");
endmodule // eqtm_monitor_sva

bind eqtm_monitor eqtm_monitor_sva #(.ADDR_W(ADDR_W)) eqtm_monitor_sva_inst (
   .clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
   .pready, .prdata, .pslverr, .valid_entry_count,
   .queue_over_limit_error, .irq);

// *** eqtm_monitor_test.sv ***
/* Self-checking bench for eqtm_monitor.
 Drives APB and the queue counts itself; no far-side model. */
`timescale 1ns/1ps
module eqtm_monitor_test import eqtm_pkg::*; ;
   logic            clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0]      paddr;
   logic [31:0]     pwdata, prdata, rd;
   logic            slv;
   logic [3:0]      pstrb, queue_over_limit_error;
   logic [3:0][4:0] valid_entry_count;
   int              err_total, comparisons;
   eqtm_monitor eqtm_monitor_inst (.clk, .sys_rst, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr,
      .valid_entry_count, .queue_over_limit_error, .irq);
   // ----
   // Clock, watchdog and verdict
   // ----
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      repeat (3000) @(posedge clk);
      err_total++;
      print_verdict();
   end
   task automatic print_verdict();
      if (err_total == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // APB transfer; pready is read at the edge, before its update lands
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // No cycle budget here; only the watchdog ends a hung wait
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask
   task automatic counts(input logic [3:0][4:0] c);
      @(posedge clk);
      valid_entry_count <= c;
   endtask
   // ----
   // Tests
   // ----
   initial begin
      {sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
      pstrb = 4'hF;
      valid_entry_count = '0;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      rchk("cfg_reset", OFF_THR_CFG, 32'h10101010);
      // Thresholds 3, off, 16, 0
      apb(1'b1, OFF_THR_CFG, 32'h00101103);
      rchk("cfg", OFF_THR_CFG, 32'h00101103);
      apb(1'b1, OFF_ERR_EN, 32'hF);
      counts({5'h00, 5'h0F, 5'h10, 5'h02});
      rchk("err_below", OFF_ERR, 32'h8);
      chk("irq_on", 32'h1, irq);
      counts({5'h00, 5'h10, 5'h10, 5'h03});
      rchk("err_meet", OFF_ERR, 32'hD);
      chk("flags", 32'hD, {28'h0, queue_over_limit_error});
      rchk("qstat2", OFF_QSTAT0 + 8'h08, 32'h01101000);
      counts('0);
      rchk("err_sticky", OFF_ERR, 32'hD);
      rchk("qstat0", OFF_QSTAT0, 32'h01030000);
      apb(1'b1, OFF_ERR_CLR, 32'h5);
      rchk("err_clr", OFF_ERR, 32'h8);
      rchk("qstat0_clr", OFF_QSTAT0, 32'h0);
      // Masking the only live flag must drop the interrupt
      apb(1'b1, OFF_ERR_EN, 32'h7);
      repeat (2) @(posedge clk);
      chk("irq_mask", 32'h0, irq);
      apb(1'b1, OFF_THR_CFG, 32'h11101103);
      apb(1'b1, OFF_ERR_CLR, 32'h8);
      rchk("err_off", OFF_ERR, 32'h0);
      rchk("unmapped", 8'h40, 32'h0);
      chk("slverr", 32'h1, {31'h0, slv});
      print_verdict();
   end
endmodule // eqtm_monitor_test
